// ### design/ppo_defs.vh
// Register offsets, field positions, reset values and constants for the pin output stage
`ifndef PPO_DEFS_VH
`define PPO_DEFS_VH

`define PPO_OFS_CHOP 12'h000
`define PPO_OFS_DUTY 12'h004
`define PPO_OFS_IOCON 12'h008
`define PPO_OFS_CTRL 12'h00C
`define PPO_OFS_UNLOCK 12'h010
`define PPO_OFS_STATUS 12'h014

`define PPO_CHOP_EN_BIT 15
`define PPO_CHOP_DIV_HI 9
`define PPO_CHOP_WMASK 16'h83FF

`define PPO_IO_HOWN 15
`define PPO_IO_LOWN 14
`define PPO_IO_HPOL 13
`define PPO_IO_LPOL 12
`define PPO_IO_MODE_HI 11
`define PPO_IO_MODE_LO 10
`define PPO_IO_HOVR 9
`define PPO_IO_LOVR 8
`define PPO_IO_OVD_HI 7
`define PPO_IO_OVD_LO 6
`define PPO_IO_FLD_HI 5
`define PPO_IO_FLD_LO 4
`define PPO_IO_CLD_HI 3
`define PPO_IO_CLD_LO 2
`define PPO_IO_RESET 16'hC000

`define PPO_CTRL_FLTMODE 0
`define PPO_CTRL_LIMMODE 1
`define PPO_CTRL_TBEN 2
`define PPO_CTRL_PRESCALE_LO 4
`define PPO_CTRL_PRESCALE_HI 6

`define PPO_MODE_COMPL 2'h0
`define PPO_MODE_REDUND 2'h1
`define PPO_MODE_PUSHPULL 2'h2

`define PPO_UNLOCK_KEY1 16'h0055
`define PPO_UNLOCK_KEY2 16'h00AA

`endif

// ### design/ppo_chop_gen.v
// Chop clock generator: prescaler followed by a 10-bit divider
`default_nettype none
module ppo_chop_gen #(
   parameter DIV_W = 10
) (
   input wire pclk,
   input wire presetn,
   input wire clk_en,
   input wire enable,
   input wire [2:0] prescale,
   input wire [DIV_W-1:0] divider,
   output reg chop_out
);
   reg [2:0] pre_cnt_r;
   reg [DIV_W-1:0] div_cnt_r;
   wire pre_tick;

   // Prescale setting n divides by n+1; a lowered setting cannot be overrun
   assign pre_tick = (pre_cnt_r >= prescale);

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pre_cnt_r <= 3'h0;
         div_cnt_r <= {DIV_W{1'b0}};
         chop_out <= 1'b0;
      end else if (clk_en) begin
         if (!enable) begin // [R1]
            pre_cnt_r <= 3'h0;
            div_cnt_r <= {DIV_W{1'b0}};
            chop_out <= 1'b0;
         end else if (pre_tick) begin // [R2]
            pre_cnt_r <= 3'h0;
            // One pulse per chop period keeps the rate exact for odd counts
            if (div_cnt_r >= divider) begin
               div_cnt_r <= {DIV_W{1'b0}};
               chop_out <= 1'b1;
            end else begin
               div_cnt_r <= div_cnt_r + {{(DIV_W-1){1'b0}}, 1'b1};
               chop_out <= 1'b0;
            end
         end else begin
            pre_cnt_r <= pre_cnt_r + 3'h1;
            chop_out <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// ### design/ppo_top.v
// PWM pin output stage with chop clock, master duty and I/O control over APB
//
// Summary of operation
// [R1] The chop generator runs only while its enable bit 15 is set.
// [R2] Chop rate is the clock over the prescaler, then over the divider plus one.
// [R3] A 16-bit read/write master duty value is offered to all generators.
// [R4] High-side ownership bit 15 hands the high pin to the PWM, else to the port.
// [R5] Low-side ownership bit 14 hands the low pin to the PWM, else to the port.
// [R6] High polarity bit 13 makes the high output active-low when set.
// [R7] Low polarity bit 12 makes the low output active-low when set.
// [R8] Pin-pair mode 00 complementary, 01 redundant, 10 push-pull, 11 reserved.
// [R9] High override enable makes the high pin follow override data bit 1.
// [R10] Low override enable makes the low pin follow override data bit 0.
// [R11] An active fault with fault mode on drives the pins from fault data.
// [R12] An active limit with limit mode on drives the pins from limit data.
// [R13] Software should not change the pair mode after the time base runs.
// [R14] With the lock option set, I/O control writes need the unlock sequence first.
// [R15] Fault beats limit, limit beats override, override beats the generator.
// [R16] In complementary mode the low output is the inverse of the high one.
`default_nettype none
`include "ppo_defs.vh"
module ppo_top #(
   parameter DIV_W = 10
) (
   input wire pclk,
   input wire presetn,
   input wire clk_en,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire io_write_lock_cfg,
   input wire gen_high,
   input wire gen_low,
   input wire fault_in,
   input wire limit_in,
   input wire gpio_high,
   input wire gpio_low,
   output reg high_output_pin,
   output reg low_output_pin,
   output reg [15:0] master_duty,
   output reg chop_clk,
   output reg time_base_enable
);
   reg [15:0] chop_r;
   reg [15:0] duty_r;
   reg [15:0] iocon_r;
   reg [6:0] ctrl_r;
   reg [1:0] unlock_st_r;
   reg fault_s1_r, fault_s2_r, limit_s1_r, limit_s2_r;
   reg lock_s1_r, lock_s2_r;
   reg locked_write_r;
   wire chop_raw;
   wire setup_ph, access_ph, wr_acc, map_hit;
   wire io_wr_ok;
   reg [15:0] rd_val;
   reg h_pre, l_pre, h_fin, l_fin;

   localparam UNL_IDLE = 2'h0;
   localparam UNL_KEY1 = 2'h1;
   localparam UNL_OPEN = 2'h2;

   function hit;
      input [11:0] a;
      begin
         hit = (a == `PPO_OFS_CHOP) || (a == `PPO_OFS_DUTY) || (a == `PPO_OFS_IOCON) ||
               (a == `PPO_OFS_CTRL) || (a == `PPO_OFS_UNLOCK) || (a == `PPO_OFS_STATUS);
      end
   endfunction

   assign setup_ph = psel && !penable;
   assign access_ph = psel && penable && pready;
   assign wr_acc = access_ph && pwrite && map_hit;
   assign map_hit = hit(paddr);
   // Lock strap is asynchronous, so it is synchronised first
   assign io_wr_ok = !lock_s2_r || (unlock_st_r == UNL_OPEN); // [R14]

   // Input synchronisers for fault, limit and lock strap
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fault_s1_r <= 1'b0;
         fault_s2_r <= 1'b0;
         limit_s1_r <= 1'b0;
         limit_s2_r <= 1'b0;
         lock_s1_r <= 1'b1;
         lock_s2_r <= 1'b1;
      end else if (clk_en) begin
         fault_s1_r <= fault_in;
         fault_s2_r <= fault_s1_r;
         limit_s1_r <= limit_in;
         limit_s2_r <= limit_s1_r;
         lock_s1_r <= io_write_lock_cfg;
         lock_s2_r <= lock_s1_r;
      end
   end

   // APB: no wait states, answer in the cycle after setup
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0;
      end else if (clk_en) begin
         pready <= setup_ph;
         pslverr <= setup_ph && !hit(paddr);
         if (setup_ph && !pwrite)
            prdata <= {16'h0, rd_val};
      end
   end

   always @* begin
      rd_val = 16'h0;
      case (paddr)
         `PPO_OFS_CHOP: rd_val = chop_r;
         `PPO_OFS_DUTY: rd_val = duty_r; // [R3]
         `PPO_OFS_IOCON: rd_val = iocon_r;
         `PPO_OFS_CTRL: rd_val = {9'h0, ctrl_r};
         `PPO_OFS_UNLOCK: rd_val = {14'h0, unlock_st_r};
         `PPO_OFS_STATUS: rd_val = {11'h0, locked_write_r, lock_s2_r, limit_s2_r,
                                    fault_s2_r, chop_raw};
         default: rd_val = 16'h0;
      endcase
   end

   // Register writes and unlock sequence
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         chop_r <= 16'h0;
         duty_r <= 16'h0;
         iocon_r <= `PPO_IO_RESET;
         ctrl_r <= 7'h0;
         unlock_st_r <= UNL_IDLE;
         locked_write_r <= 1'b0;
      end else if (clk_en && wr_acc) begin
         case (paddr)
            `PPO_OFS_CHOP: chop_r <= pwdata[15:0] & `PPO_CHOP_WMASK;
            `PPO_OFS_DUTY: duty_r <= pwdata[15:0]; // [R3]
            `PPO_OFS_IOCON: begin
               if (io_wr_ok) begin // [R14]
                  iocon_r <= pwdata[15:0];
               end else begin
                  locked_write_r <= 1'b1;
               end
               unlock_st_r <= UNL_IDLE;
            end
            `PPO_OFS_CTRL: ctrl_r <= pwdata[6:0];
            `PPO_OFS_UNLOCK: begin
               case (unlock_st_r)
                  UNL_IDLE: unlock_st_r <= (pwdata[15:0] == `PPO_UNLOCK_KEY1) ?
                                           UNL_KEY1 : UNL_IDLE;
                  UNL_KEY1: unlock_st_r <= (pwdata[15:0] == `PPO_UNLOCK_KEY2) ?
                                           UNL_OPEN : UNL_IDLE;
                  default: unlock_st_r <= UNL_IDLE;
               endcase
            end
            `PPO_OFS_STATUS: locked_write_r <= 1'b0;
            default: unlock_st_r <= unlock_st_r;
         endcase
      end
   end

   ppo_chop_gen #(
      .DIV_W(DIV_W)
   ) u_chop (
      .pclk(pclk),
      .presetn(presetn),
      .clk_en(clk_en),
      .enable(chop_r[`PPO_CHOP_EN_BIT]), // [R1]
      .prescale(ctrl_r[`PPO_CTRL_PRESCALE_HI:`PPO_CTRL_PRESCALE_LO]), // [R2]
      .divider(chop_r[DIV_W-1:0]),
      .chop_out(chop_raw)
   );

   // Output priority chain before polarity
   always @* begin
      case (iocon_r[`PPO_IO_MODE_HI:`PPO_IO_MODE_LO]) // [R8]
         `PPO_MODE_COMPL: begin
            h_pre = gen_high;
            l_pre = ~gen_high; // [R16]
         end
         `PPO_MODE_REDUND: begin
            h_pre = gen_high;
            l_pre = gen_high;
         end
         `PPO_MODE_PUSHPULL: begin
            h_pre = gen_high;
            l_pre = gen_low;
         end
         default: begin
            h_pre = 1'b0;
            l_pre = 1'b0;
         end
      endcase
      if (iocon_r[`PPO_IO_HOVR])
         h_pre = iocon_r[`PPO_IO_OVD_HI]; // [R9]
      if (iocon_r[`PPO_IO_LOVR])
         l_pre = iocon_r[`PPO_IO_OVD_LO]; // [R10]
      if (limit_s2_r && ctrl_r[`PPO_CTRL_LIMMODE]) begin // [R12] [R15]
         h_pre = iocon_r[`PPO_IO_CLD_HI];
         l_pre = iocon_r[`PPO_IO_CLD_LO];
      end
      if (fault_s2_r && ctrl_r[`PPO_CTRL_FLTMODE]) begin // [R11] [R15]
         h_pre = iocon_r[`PPO_IO_FLD_HI];
         l_pre = iocon_r[`PPO_IO_FLD_LO];
      end
      h_fin = iocon_r[`PPO_IO_HOWN] ? (h_pre ^ iocon_r[`PPO_IO_HPOL]) : gpio_high; // [R4] [R6]
      l_fin = iocon_r[`PPO_IO_LOWN] ? (l_pre ^ iocon_r[`PPO_IO_LPOL]) : gpio_low; // [R5] [R7]
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         high_output_pin <= 1'b0;
         low_output_pin <= 1'b0;
         master_duty <= 16'h0;
         chop_clk <= 1'b0;
         time_base_enable <= 1'b0;
      end else if (clk_en) begin
         high_output_pin <= h_fin;
         low_output_pin <= l_fin;
         master_duty <= duty_r;
         chop_clk <= chop_raw;
         time_base_enable <= ctrl_r[`PPO_CTRL_TBEN];
      end
   end
endmodule
`default_nettype wire

// ### verif/ppo_stage.sv
// Power stage model: the half bridge sees the pin pair as one phase code
`default_nettype none
module ppo_stage (
   input wire logic high_drive,
   input wire logic low_drive,
   output logic [1:0] phase
);
   timeunit 1ns;
   timeprecision 1ps;
   assign phase = {high_drive, low_drive};
endmodule
`default_nettype wire

// ### verif/ppo_top_monitor.sv
// Port checks for the pin output stage
`default_nettype none
module ppo_top_monitor #(
   parameter DIV_W = 10
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [15:0] master_duty,
   input wire logic chop_clk,
   input wire logic time_base_enable
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   setup_gets_ready_a: assert property (psel && !penable && clk_en |=> pready)
      else $error("no ready after setup");
   ready_in_access_a: assert property (pready |-> psel && penable)
      else $error("ready outside access");
   ready_one_cycle_a: assert property (pready && clk_en |=> !pready)
      else $error("ready too long");
   error_with_ready_a: assert property (pslverr |-> pready)
      else $error("error without ready");
   unmapped_refused_a: assert property (
      pready && !pwrite && paddr > 12'h014 |-> pslverr && prdata == 32'h0)
      else $error("unmapped read accepted");
   duty_written_a: assert property (
      pready && pwrite && clk_en && paddr == 12'h004 ##1 clk_en
      |=> master_duty == $past(pwdata[15:0], 2)) else $error("duty not written");
   tbase_written_a: assert property (
      pready && pwrite && clk_en && paddr == 12'h00C ##1 clk_en
      |=> time_base_enable == $past(pwdata[2], 2)) else $error("time base bit");
   chop_frozen_a: assert property (!clk_en |=> $stable(chop_clk))
      else $error("chop moved while stalled");
endmodule
bind ppo_top ppo_top_monitor #(.DIV_W(DIV_W)) u_mon (.pclk(pclk), .presetn(presetn),
   .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .master_duty(master_duty), .chop_clk(chop_clk), .time_base_enable(time_base_enable));
`default_nettype wire

// ### verif/tb.sv
// Self-checking bench for the pin output stage
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk = 0, presetn = 0, clk_en = 1, psel = 0, penable = 0, pwrite = 0, lk = 1;
   logic gh = 0, gl = 0, f = 0, l = 0, ph = 0, pl = 0, rerr, pready, pslverr, hp, lp;
   logic chop, tb_en;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rdat;
   logic [15:0] duty, io;
   logic [2:0] ct;
   logic [1:0] phase;
   int failures = 0, comparisons = 0, seed = 51636, cyc = 0, n;
   ppo_top DUT (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .io_write_lock_cfg(lk), .gen_high(gh),
      .gen_low(gl), .fault_in(f), .limit_in(l), .gpio_high(ph), .gpio_low(pl),
      .high_output_pin(hp), .low_output_pin(lp), .master_duty(duty), .chop_clk(chop),
      .time_base_enable(tb_en));
   ppo_stage STG (.high_drive(hp), .low_drive(lp), .phase(phase));
   initial forever #2 pclk = ~pclk;
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 30000) begin
         failures++;
         give_verdict;
      end
   end
   task give_verdict;
      $display("failures %0d comparisons %0d", failures, comparisons);
      if (failures == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         failures++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task rd(input logic [11:0] a, input logic [31:0] e);
      apb(0, a, 32'h0);
      cmp("read", e, rdat);
   endtask
   task wio(input logic [15:0] v);
      apb(1, 12'h010, 32'h55);
      apb(1, 12'h010, 32'hAA);
      apb(1, 12'h008, {16'h0, v});
   endtask
   function logic [1:0] pins(input logic [15:0] v, input logic [2:0] c);
      logic h, q;
      h = gh;
      q = (v[11:10] == 2'h0) ? ~gh : (v[11:10] == 2'h1) ? gh : gl;
      if (v[9]) h = v[7];
      if (v[8]) q = v[6];
      if (l && c[1]) {h, q} = v[3:2];
      if (f && c[0]) {h, q} = v[5:4];
      h = h ^ v[13];
      q = q ^ v[12];
      if (!v[15]) h = ph;
      if (!v[14]) q = pl;
      return {h, q};
   endfunction
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1;
      rd(12'h000, 32'h0);
      rd(12'h004, 32'h0);
      rd(12'h008, 32'hC000);
      rd(12'h00C, 32'h0);
      rd(12'h020, 32'h0);
      cmp("slverr", 32'h1, {31'h0, rerr});
      apb(1, 12'h008, 32'h0);
      rd(12'h008, 32'hC000);
      rd(12'h014, 32'h18);
      apb(1, 12'h014, 32'h0);
      rd(12'h014, 32'h8);
      n = $random(seed);
      apb(1, 12'h004, n);
      rd(12'h004, n & 32'hFFFF);
      cmp("duty", n & 32'hFFFF, {16'h0, duty});
      apb(1, 12'h000, 32'hFFFF);
      rd(12'h000, 32'h83FF);
      // Prescale by two, divider three: six cycles per period
      apb(1, 12'h00C, 32'h10);
      apb(1, 12'h000, 32'h8002);
      @(posedge chop);
      n = cyc;
      @(posedge chop);
      cmp("chop period", 32'h6, cyc - n);
      apb(1, 12'h000, 32'h2);
      repeat (2) @(posedge pclk);
      n = 0;
      repeat (12) begin
         @(posedge pclk);
         n += chop;
      end
      cmp("chop stopped", 32'h0, n);
      for (int i = 0; i < 30; i++) begin
         io = 16'($random(seed));
         io[11:10] = 2'(i % 3);
         ct = 3'($random(seed));
         ct[2] = 0;
         apb(1, 12'h00C, {29'h0, ct});
         wio(io);
         n = $random(seed);
         {gh, gl, f, l, ph, pl} <= n[5:0];
         repeat (4) @(posedge pclk);
         cmp("pins", {30'h0, pins(io, ct)}, {30'h0, phase});
      end
      // Lock option off: plain write accepted without unlock
      lk <= 0;
      repeat (3) @(posedge pclk);
      apb(1, 12'h008, 32'h3000);
      rd(12'h008, 32'h3000);
      apb(1, 12'h00C, 32'h4);
      repeat (2) @(posedge pclk);
      cmp("time base", 32'h1, {31'h0, tb_en});
      // Chop running while the clock enable stalls
      apb(1, 12'h000, 32'h8001);
      repeat (16) begin
         n = $random(seed);
         clk_en <= n[0];
         @(posedge pclk);
      end
      clk_en <= 1;
      give_verdict;
   end
endmodule
`default_nettype wire
